//--- logic/rtcc_counter.sv
// rtcc_counter: 16-bit real-time counter with prescaler and periodic tick timer
//
// Function
// - 16-bit counter advances on prescaled ticks, compared with period and compare.
// - compare flag and event raised on the count tick after count equals compare.
// - overflow flag and event on tick after count equals period; reload zero.
// - source select: external clock, internal 32 kHz oscillator, oscillator divided by 32.
// - programmable prescaler up to 15 bits between source and counter.
// - tick timer on same clock; irq 4..32768 periods, events 64..8192.
// - tick timer has its own enable, independent of counter enable.
// - debug halt stops counting unless debug-run bit is one.
// - writing one to enable bit starts counter, zero stops it.
// - overflow and compare each have irq path and event; irq gated by enable.
// - counter may keep running in sleep and wake the device.
// - condition sets flag; irq stays high while flag and enable set.
// - eight tick events; event 0 every 8192 periods, each next halves to 64.
// - writes crossing to slow clock set busy flags; software checks first.
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module rtcc_counter (
   input  wire logic                        ref_clk_in,
   input  wire logic                        reset_n_in,
   input  wire logic [rtcc_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [rtcc_pkg::DATA_W-1:0] wr_data_in,
   input  wire logic                        wr_en_in,
   input  wire logic                        rd_en_in,
   output logic      [rtcc_pkg::DATA_W-1:0] rd_data_out,
   input  wire logic                        ext_clk_in,
   input  wire logic                        ulp_osc_clk_in,
   input  wire logic                        debug_halt_in,
   input  wire logic                        standby_in,
   output logic                             counter_irq_out,
   output logic                             tick_irq_out,
   output rtcc_pkg::rtcc_event_s            events_out
);
   import rtcc_pkg::*;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // low-bit mask of 2**exp - 1, exp up to 15
   function automatic logic [PRE_W-1:0] low_mask(input logic [4:0] exp);
      logic [PRE_W:0] one_hot;
      one_hot  = (PRE_W+1)'(1) << exp;
      low_mask = PRE_W'(one_hot - (PRE_W+1)'(1));
   endfunction : low_mask

   function automatic logic all_ones(input logic [PRE_W-1:0] value,
                                     input logic [PRE_W-1:0] mask);
      all_ones = ((value & mask) == mask);
   endfunction : all_ones

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic [2:0]            ext_sync_reg;
   logic [2:0]            ulp_sync_reg;
   logic [ULP_DIV_W-1:0]  ulp_div_reg;
   rtcc_ctrl_s            ctrl_reg, ctrl_stage_reg;
   rtcc_tick_ctrl_s       tick_ctrl_reg, tick_stage_reg;
   logic [CNT_W-1:0]      count_reg, count_stage_reg;
   logic [CNT_W-1:0]      period_reg, period_stage_reg;
   logic [CNT_W-1:0]      compare_reg, compare_stage_reg;
   logic [3:0]            busy_reg, busy_next;
   logic                  tick_busy_reg, tick_busy_next;
   logic [1:0]            int_en_reg, flags_reg, flags_next;
   logic                  tick_int_en_reg, tick_flag_reg, tick_flag_next;
   logic                  debug_run_reg, tick_debug_run_reg;
   logic [1:0]            clk_sel_reg;
   logic [DATA_W-1:0]     temp_reg;
   logic [PRE_W-1:0]      presc_reg, tick_cnt_reg;
   logic [DATA_W-1:0]     rd_data_reg, rd_data_next;
   logic                  counter_irq_reg, tick_irq_reg;
   rtcc_event_s           events_reg, events_next;

   // ----------------------------------------------------------------------
   // slow clock selection
   // ----------------------------------------------------------------------
   // edges are taken from the second and third stage only
   wire ext_edge  = ext_sync_reg[1] & ~ext_sync_reg[2];
   wire ulp_edge  = ulp_sync_reg[1] & ~ulp_sync_reg[2];
   wire div_edge  = ulp_edge & (&ulp_div_reg);
   wire rtcc_clk_src_e src_sel = rtcc_clk_src_e'(clk_sel_reg);
   wire slow_tick = (src_sel == RTCC_SRC_ULP)       ? ulp_edge :
                    (src_sel == RTCC_SRC_ULP_DIV32) ? div_edge :
                                                      ext_edge;

   // ----------------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------------
   wire wr_ctrl      = wr_en_in & (addr_in == ADDR_CTRL);
   wire wr_int_en    = wr_en_in & (addr_in == ADDR_INT_EN);
   wire wr_flags     = wr_en_in & (addr_in == ADDR_INT_FLAGS);
   wire wr_temp      = wr_en_in & (addr_in == ADDR_TEMP);
   wire wr_debug     = wr_en_in & (addr_in == ADDR_DEBUG);
   wire wr_clk_sel   = wr_en_in & (addr_in == ADDR_CLOCK_SEL);
   wire wr_count_hi  = wr_en_in & (addr_in == ADDR_COUNT_HI);
   wire wr_period_hi = wr_en_in & (addr_in == ADDR_PERIOD_HI);
   wire wr_comp_hi   = wr_en_in & (addr_in == ADDR_COMPARE_HI);
   wire wr_tick_ctrl = wr_en_in & (addr_in == ADDR_TICK_CTRL);
   wire wr_tick_en   = wr_en_in & (addr_in == ADDR_TICK_INT_EN);
   wire wr_tick_flag = wr_en_in & (addr_in == ADDR_TICK_FLAGS);
   wire wr_tick_dbg  = wr_en_in & (addr_in == ADDR_TICK_DEBUG);
   wire wr_any_lo    = wr_en_in & ((addr_in == ADDR_COUNT_LO) |
                                   (addr_in == ADDR_PERIOD_LO) |
                                   (addr_in == ADDR_COMPARE_LO));
   wire rd_count_lo  = rd_en_in & (addr_in == ADDR_COUNT_LO);
   wire rd_period_lo = rd_en_in & (addr_in == ADDR_PERIOD_LO);
   wire rd_comp_lo   = rd_en_in & (addr_in == ADDR_COMPARE_LO);
   // 16-bit words go through the temp byte so both halves are coherent
   wire [CNT_W-1:0] wide_wr = {wr_data_in, temp_reg};
   wire [3:0] busy_set = {wr_comp_hi, wr_period_hi, wr_count_hi, wr_ctrl};

   // ----------------------------------------------------------------------
   // counter datapath
   // ----------------------------------------------------------------------
   wire counter_run = ctrl_reg.counter_enable_bit &
                      ~(debug_halt_in & ~debug_run_reg) &
                      ~(standby_in & ~ctrl_reg.run_standby);
   wire [PRE_W-1:0] presc_mask = low_mask({1'b0, ctrl_reg.prescale_setting});
   wire count_tick = counter_run & slow_tick & all_ones(presc_reg, presc_mask);
   wire count_load = slow_tick & busy_reg[BIT_COUNT_BUSY] & ~wr_count_hi;
   // a count reload from software takes precedence over the hit that tick
   wire at_period  = count_tick & ~count_load & (count_reg == period_reg);
   wire at_compare = count_tick & ~count_load & (count_reg == compare_reg);
   wire [1:0] hit  = {at_compare, at_period};
   wire [CNT_W-1:0] count_inc = count_reg + CNT_W'(1);

   // ----------------------------------------------------------------------
   // tick timer datapath
   // ----------------------------------------------------------------------
   wire tick_run  = tick_ctrl_reg.tick_timer_enable &
                    ~(debug_halt_in & ~tick_debug_run_reg);
   wire tick_step = tick_run & slow_tick;
   wire [4:0] tick_exp = 5'(tick_ctrl_reg.interval) + 5'(TICK_EXP_OFS);
   wire tick_code_ok = (tick_ctrl_reg.interval != 4'h0) &
                       (tick_ctrl_reg.interval <= TICK_CODE_MAX);
   wire tick_hit = tick_step & tick_code_ok &
                   all_ones(tick_cnt_reg, low_mask(tick_exp));
   logic [EVENT_COUNT-1:0] tick_evt;

   genvar gi;
   generate
      for (gi = 0; gi < EVENT_COUNT; gi++) begin : g_tick_evt
         localparam logic [4:0] EXP = 5'(EVENT_TOP_EXP - gi);
         assign tick_evt[gi] = tick_step & all_ones(tick_cnt_reg, low_mask(EXP));
      end
   endgenerate

   // ----------------------------------------------------------------------
   // flags, busy and event combination
   // ----------------------------------------------------------------------
   // a hit in the clearing cycle survives: set wins over clear
   assign flags_next     = (flags_reg & ~(wr_flags ? wr_data_in[1:0] : 2'b00)) | hit;
   assign tick_flag_next = (tick_flag_reg & ~(wr_tick_flag & wr_data_in[BIT_TICK_IRQ])) |
                           tick_hit;
   assign busy_next      = busy_set | (slow_tick ? 4'h0 : busy_reg);
   assign tick_busy_next = wr_tick_ctrl | (slow_tick ? 1'b0 : tick_busy_reg);
   assign events_next.overflow = at_period;
   assign events_next.compare  = at_compare;
   assign events_next.tick     = tick_evt;

   // ----------------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------------
   always_comb begin
      rd_data_next = BYTE_ZERO;
      if (!rd_en_in) begin
         rd_data_next = BYTE_ZERO;
      end else if (addr_in == ADDR_CTRL) begin
         rd_data_next = ctrl_stage_reg;
      end else if (addr_in == ADDR_STATUS) begin
         rd_data_next = {4'h0, busy_reg};
      end else if (addr_in == ADDR_INT_EN) begin
         rd_data_next = {6'h00, int_en_reg};
      end else if (addr_in == ADDR_INT_FLAGS) begin
         rd_data_next = {6'h00, flags_reg};
      end else if ((addr_in == ADDR_TEMP) || (addr_in == ADDR_COUNT_HI) ||
                   (addr_in == ADDR_PERIOD_HI) || (addr_in == ADDR_COMPARE_HI)) begin
         rd_data_next = temp_reg;
      end else if (addr_in == ADDR_DEBUG) begin
         rd_data_next = {7'h00, debug_run_reg};
      end else if (addr_in == ADDR_CLOCK_SEL) begin
         rd_data_next = {6'h00, clk_sel_reg};
      end else if (addr_in == ADDR_COUNT_LO) begin
         rd_data_next = count_reg[DATA_W-1:0];
      end else if (addr_in == ADDR_PERIOD_LO) begin
         rd_data_next = period_stage_reg[DATA_W-1:0];
      end else if (addr_in == ADDR_COMPARE_LO) begin
         rd_data_next = compare_stage_reg[DATA_W-1:0];
      end else if (addr_in == ADDR_TICK_CTRL) begin
         rd_data_next = tick_stage_reg;
      end else if (addr_in == ADDR_TICK_STATUS) begin
         rd_data_next = {7'h00, tick_busy_reg};
      end else if (addr_in == ADDR_TICK_INT_EN) begin
         rd_data_next = {7'h00, tick_int_en_reg};
      end else if (addr_in == ADDR_TICK_FLAGS) begin
         rd_data_next = {7'h00, tick_flag_reg};
      end else if (addr_in == ADDR_TICK_DEBUG) begin
         rd_data_next = {7'h00, tick_debug_run_reg};
      end else begin
         rd_data_next = BYTE_ZERO;
      end
   end

   // ----------------------------------------------------------------------
   // pin synchronisers and source divider
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         ext_sync_reg <= 3'h0;
         ulp_sync_reg <= 3'h0;
         ulp_div_reg  <= '0;
      end else begin
         ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_in};
         ulp_sync_reg <= {ulp_sync_reg[1:0], ulp_osc_clk_in};
         ulp_div_reg  <= ulp_edge ? ulp_div_reg + ULP_DIV_W'(1) : ulp_div_reg;
      end
   end

   // ----------------------------------------------------------------------
   // software-written registers
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         ctrl_stage_reg     <= '0;
         tick_stage_reg     <= '0;
         count_stage_reg    <= COUNT_RESET;
         period_stage_reg   <= PERIOD_RESET;
         compare_stage_reg  <= COMPARE_RESET;
         int_en_reg         <= 2'b00;
         tick_int_en_reg    <= 1'b0;
         debug_run_reg      <= 1'b0;
         tick_debug_run_reg <= 1'b0;
         clk_sel_reg        <= 2'b00;
      end else begin
         if (wr_ctrl)      ctrl_stage_reg     <= wr_data_in;
         if (wr_tick_ctrl) tick_stage_reg     <= wr_data_in;
         if (wr_count_hi)  count_stage_reg    <= wide_wr;
         if (wr_period_hi) period_stage_reg   <= wide_wr;
         if (wr_comp_hi)   compare_stage_reg  <= wide_wr;
         if (wr_int_en)    int_en_reg         <= wr_data_in[1:0];
         if (wr_tick_en)   tick_int_en_reg    <= wr_data_in[BIT_TICK_IRQ];
         if (wr_debug)     debug_run_reg      <= wr_data_in[BIT_DEBUG_RUN];
         if (wr_tick_dbg)  tick_debug_run_reg <= wr_data_in[BIT_DEBUG_RUN];
         if (wr_clk_sel)   clk_sel_reg        <= wr_data_in[1:0];
      end
   end

   // temp byte: low-byte writes park here, low-byte reads park the high half
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         temp_reg <= BYTE_ZERO;
      end else if (wr_any_lo || wr_temp) begin
         temp_reg <= wr_data_in;
      end else if (rd_count_lo) begin
         temp_reg <= count_reg[CNT_W-1:DATA_W];
      end else if (rd_period_lo) begin
         temp_reg <= period_stage_reg[CNT_W-1:DATA_W];
      end else if (rd_comp_lo) begin
         temp_reg <= compare_stage_reg[CNT_W-1:DATA_W];
      end
   end

   // ----------------------------------------------------------------------
   // slow-domain registers: staged values land on the next slow clock edge
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         busy_reg      <= 4'h0;
         tick_busy_reg <= 1'b0;
         ctrl_reg      <= '0;
         tick_ctrl_reg <= '0;
         period_reg    <= PERIOD_RESET;
         compare_reg   <= COMPARE_RESET;
      end else begin
         busy_reg      <= busy_next;
         tick_busy_reg <= tick_busy_next;
         // a write in the very tick cycle keeps busy and lands on the next edge
         if (slow_tick && busy_reg[BIT_CTRL_BUSY] && !wr_ctrl)
            ctrl_reg <= ctrl_stage_reg;
         if (slow_tick && tick_busy_reg && !wr_tick_ctrl)
            tick_ctrl_reg <= tick_stage_reg;
         if (slow_tick && busy_reg[BIT_PERIOD_BUSY] && !wr_period_hi)
            period_reg <= period_stage_reg;
         if (slow_tick && busy_reg[BIT_COMPARE_BUSY] && !wr_comp_hi)
            compare_reg <= compare_stage_reg;
      end
   end

   // ----------------------------------------------------------------------
   // counter, prescaler and tick timer
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         count_reg    <= COUNT_RESET;
         presc_reg    <= '0;
         tick_cnt_reg <= '0;
      end else begin
         if (count_load)
            count_reg <= count_stage_reg;
         else if (at_period)
            count_reg <= COUNT_RESET;
         else if (count_tick)
            count_reg <= count_inc;
         if (!ctrl_reg.counter_enable_bit)
            presc_reg <= '0;
         else if (counter_run && slow_tick)
            presc_reg <= presc_reg + PRE_W'(1);
         if (!tick_ctrl_reg.tick_timer_enable)
            tick_cnt_reg <= '0;
         else if (tick_step)
            tick_cnt_reg <= tick_cnt_reg + PRE_W'(1);
      end
   end

   // ----------------------------------------------------------------------
   // flags, requests, events and read data
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         flags_reg       <= 2'b00;
         tick_flag_reg   <= 1'b0;
         counter_irq_reg <= 1'b0;
         tick_irq_reg    <= 1'b0;
         events_reg      <= '0;
         rd_data_reg     <= BYTE_ZERO;
      end else begin
         flags_reg       <= flags_next;
         tick_flag_reg   <= tick_flag_next;
         counter_irq_reg <= |(flags_next & int_en_reg);
         tick_irq_reg    <= tick_flag_next & tick_int_en_reg;
         events_reg      <= events_next;
         rd_data_reg     <= rd_data_next;
      end
   end

   assign rd_data_out     = rd_data_reg;
   assign counter_irq_out = counter_irq_reg;
   assign tick_irq_out    = tick_irq_reg;
   assign events_out      = events_reg;
endmodule : rtcc_counter

`default_nettype wire

//--- shared/rtcc_pkg.sv
// rtcc_pkg: register map, field layout and carrier types of the real-time counter
package rtcc_pkg;
   // ----------------------------------------------------------------------
   // register bus shape
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int CNT_W  = 16;
   localparam int PRE_W  = 15;

   // ----------------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_CTRL        = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS      = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_INT_EN      = 8'h02;
   localparam logic [ADDR_W-1:0] ADDR_INT_FLAGS   = 8'h03;
   localparam logic [ADDR_W-1:0] ADDR_TEMP        = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_DEBUG       = 8'h05;
   localparam logic [ADDR_W-1:0] ADDR_CLOCK_SEL   = 8'h07;
   localparam logic [ADDR_W-1:0] ADDR_COUNT_LO    = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_COUNT_HI    = 8'h09;
   localparam logic [ADDR_W-1:0] ADDR_PERIOD_LO   = 8'h0A;
   localparam logic [ADDR_W-1:0] ADDR_PERIOD_HI   = 8'h0B;
   localparam logic [ADDR_W-1:0] ADDR_COMPARE_LO  = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_COMPARE_HI  = 8'h0D;
   localparam logic [ADDR_W-1:0] ADDR_TICK_CTRL   = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_TICK_STATUS = 8'h11;
   localparam logic [ADDR_W-1:0] ADDR_TICK_INT_EN = 8'h12;
   localparam logic [ADDR_W-1:0] ADDR_TICK_FLAGS  = 8'h13;
   localparam logic [ADDR_W-1:0] ADDR_TICK_DEBUG  = 8'h15;

   // ----------------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------------
   localparam int BIT_OVERFLOW     = 0;
   localparam int BIT_COMPARE      = 1;
   localparam int BIT_DEBUG_RUN    = 0;
   localparam int BIT_TICK_IRQ     = 0;
   localparam int BIT_CTRL_BUSY    = 0;
   localparam int BIT_COUNT_BUSY   = 1;
   localparam int BIT_PERIOD_BUSY  = 2;
   localparam int BIT_COMPARE_BUSY = 3;
   localparam logic [CNT_W-1:0]  PERIOD_RESET  = 16'hFFFF;
   localparam logic [CNT_W-1:0]  COUNT_RESET   = 16'h0000;
   localparam logic [CNT_W-1:0]  COMPARE_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] BYTE_ZERO     = 8'h00;

   // ----------------------------------------------------------------------
   // clock sources and tick timer figures
   // ----------------------------------------------------------------------
   localparam int ULP_DIV_W     = 5;   // divide by 32
   localparam int EVENT_COUNT   = 8;
   localparam int EVENT_TOP_EXP = 13;  // event 0 every 2**13 = 8192 periods
   localparam int TICK_EXP_OFS  = 1;   // period code v gives 2**(v+1) periods
   localparam logic [3:0] TICK_CODE_MAX = 4'hE;

   typedef enum logic [1:0] {
      RTCC_SRC_ULP       = 2'b00,
      RTCC_SRC_ULP_DIV32 = 2'b01,
      RTCC_SRC_EXT       = 2'b10
   } rtcc_clk_src_e;

   // control byte: bit 7 standby run, bits 6:3 divider code, bit 0 enable
   typedef struct packed {
      logic       run_standby;
      logic [3:0] prescale_setting;
      logic [1:0] reserved;
      logic       counter_enable_bit;
   } rtcc_ctrl_s;

   // tick timer control byte: bits 6:3 interval code, bit 0 enable
   typedef struct packed {
      logic       reserved_hi;
      logic [3:0] interval;
      logic [1:0] reserved;
      logic       tick_timer_enable;
   } rtcc_tick_ctrl_s;

   typedef struct packed {
      logic [EVENT_COUNT-1:0] tick;
      logic                   compare;
      logic                   overflow;
   } rtcc_event_s;
endpackage : rtcc_pkg

//--- verif/rtcc_counter_props.sv
// rtcc_counter_props: port-level assertions for the real-time counter
`timescale 1ns/1ps
`default_nettype none
module rtcc_counter_props (
   input  wire logic                        ref_clk_in,
   input  wire logic                        reset_n_in,
   input  wire logic [rtcc_pkg::ADDR_W-1:0] addr_in,
   input  wire logic                        wr_en_in,
   input  wire logic                        rd_en_in,
   input  wire logic [rtcc_pkg::DATA_W-1:0] rd_data_out,
   input  wire logic                        counter_irq_out,
   input  wire logic                        tick_irq_out,
   input  wire rtcc_pkg::rtcc_event_s       events_out
);
   import rtcc_pkg::*;
   // a clear or enable write may drop the request two cycles later
   wire logic clr_w  = wr_en_in && (addr_in == ADDR_INT_FLAGS || addr_in == ADDR_INT_EN);
   wire logic tclr_w = wr_en_in && (addr_in == ADDR_TICK_FLAGS || addr_in == ADDR_TICK_INT_EN);
   wire logic ev_w   = events_out.overflow || events_out.compare;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);
   a_ovf_single: assert property (events_out.overflow |=> !events_out.overflow)
      else $error("overflow event wider than one cycle");
   a_cmp_single: assert property (events_out.compare |=> !events_out.compare)
      else $error("compare event wider than one cycle");
   a_tick_single: assert property (events_out.tick[7] |=> !events_out.tick[7])
      else $error("tick event wider than one cycle");
   a_irq_hold: assert property (counter_irq_out && !clr_w && !$past(clr_w) |=> counter_irq_out)
      else $error("counter irq dropped without a clear");
   a_tick_irq_hold: assert property (tick_irq_out && !tclr_w && !$past(tclr_w) |=> tick_irq_out)
      else $error("tick irq dropped without a clear");
   a_irq_cause: assert property ($rose(counter_irq_out) |->
      ev_w || $past(ev_w) || $past(clr_w) || $past(clr_w, 2))
      else $error("counter irq rose without an event");
   a_rd_idle: assert property (!$past(rd_en_in) |-> rd_data_out == BYTE_ZERO)
      else $error("read data not zero outside a read");
   a_rd_unmapped: assert property ($past(rd_en_in && addr_in == 8'h06) |-> rd_data_out == 8'h00)
      else $error("unmapped read not zero");
endmodule : rtcc_counter_props
bind rtcc_counter rtcc_counter_props u_rtcc_counter_props (.ref_clk_in(ref_clk_in),
   .reset_n_in(reset_n_in), .addr_in(addr_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
   .rd_data_out(rd_data_out), .counter_irq_out(counter_irq_out), .tick_irq_out(tick_irq_out),
   .events_out(events_out));
`default_nettype wire

//--- verif/tb_top.sv
// tb_top: register-level scenarios for the real-time counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rtcc_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, halt = 1'b0, osc = 1'b0, ext = 1'b0;
   logic [7:0]  addr = 8'h00, wdat = 8'h00, rdat, srcs [3] = '{8'h02, 8'h01, 8'h00};
   logic        cirq, tirq, stby = 1'b0;
   rtcc_event_s ev;
   int          mismatches = 0, checks_done = 0, gaps [3] = '{168, 3840, 120};
   always #2 clk = ~clk;
   // slow clocks never toggle on a rising ref edge, so gaps are exact
   always #20 osc = ~osc;
   always #28 ext = ~ext;
   rtcc_counter u_rtcc_counter (.ref_clk_in(clk), .reset_n_in(rst_n), .addr_in(addr),
      .wr_data_in(wdat), .wr_en_in(wr), .rd_en_in(rd), .rd_data_out(rdat), .ext_clk_in(ext),
      .ulp_osc_clk_in(osc), .debug_halt_in(halt), .standby_in(stby), .counter_irq_out(cirq),
      .tick_irq_out(tirq), .events_out(ev));
   task automatic wrap_up();
      if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic wr_reg(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(logic [7:0] a, logic [7:0] exp, string what);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(what, {8'h00, exp}, {8'h00, rdat});
   endtask : rd_reg
   // cycles from event bit s to the next pulse of event bit t
   task automatic gap(int s, int t, int exp, string what);
      int n;
      n = 0;
      while (ev[s] !== 1'b1 && n < 5000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 5000) begin
         chk(what, exp[15:0], 16'hFFFF);
         wrap_up();
      end
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ev[t] !== 1'b1 && n < 5000);
      chk(what, exp[15:0], n[15:0]);
      if (n >= 5000) wrap_up();
   endtask : gap
   initial begin
      int n;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(ADDR_PERIOD_LO, 8'hFF, "period_lo reset");
      rd_reg(ADDR_PERIOD_HI, 8'hFF, "period_hi reset");
      rd_reg(ADDR_COUNT_LO, 8'h00, "count reset");
      wr_reg(8'h06, 8'h5A);
      rd_reg(8'h06, 8'h00, "unmapped");
      wr_reg(ADDR_PERIOD_LO, 8'h05);
      wr_reg(ADDR_PERIOD_HI, 8'h00);
      // read lands before the next slow edge, so period busy still stands
      rd_reg(ADDR_STATUS, 8'h04, "status period busy");
      wr_reg(ADDR_COMPARE_LO, 8'h02);
      wr_reg(ADDR_COMPARE_HI, 8'h00);
      wr_reg(ADDR_INT_EN, 8'h03);
      wr_reg(ADDR_CTRL, 8'h01);
      gap(0, 0, 60, "overflow gap");
      gap(1, 0, 30, "compare to overflow");
      rd_reg(ADDR_INT_FLAGS, 8'h03, "int flags");
      chk("counter irq", 16'h0001, {15'h0000, cirq});
      wr_reg(ADDR_INT_FLAGS, 8'h03);
      @(posedge clk);
      #1 chk("counter irq cleared", 16'h0000, {15'h0000, cirq});
      wr_reg(ADDR_CTRL, 8'h09);
      for (int i = 0; i < 3; i++) begin
         wr_reg(ADDR_CLOCK_SEL, srcs[i]);
         repeat (20) @(posedge clk);
         gap(0, 0, gaps[i], "overflow gap per source");
      end
      halt <= 1'b1;
      repeat (10) @(posedge clk);
      n = 0;
      repeat (400) begin
         @(posedge clk);
         n += int'(ev.overflow === 1'b1);
      end
      chk("overflows while halted", 16'h0000, n[15:0]);
      wr_reg(ADDR_DEBUG, 8'h01);
      repeat (20) @(posedge clk);
      gap(0, 0, 120, "overflow gap debug run");
      stby <= 1'b1;
      repeat (10) @(posedge clk);
      n = 0;
      repeat (400) begin
         @(posedge clk);
         n += int'(ev.overflow === 1'b1);
      end
      chk("overflows in standby", 16'h0000, n[15:0]);
      wr_reg(ADDR_CTRL, 8'h89);
      repeat (20) @(posedge clk);
      gap(0, 0, 120, "overflow gap run in standby");
      halt <= 1'b0;
      stby <= 1'b0;
      wr_reg(ADDR_CTRL, 8'h00);
      wr_reg(ADDR_TICK_INT_EN, 8'h01);
      wr_reg(ADDR_TICK_CTRL, 8'h09);
      gap(9, 9, 640, "tick event 7 gap");
      gap(8, 8, 1280, "tick event 6 gap");
      chk("tick irq", 16'h0001, {15'h0000, tirq});
      rd_reg(ADDR_TICK_FLAGS, 8'h01, "tick flag");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
